// ### rtl/pllsy_core.sv
// Synthesizer core: dividers, phase detector, lock flag, AHB-Lite registers
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
module pllsy_core (
  input  wire logic                          ref_clk_in,
  input  wire logic                          rst_b_in,
  // Static programming pins: one means switch closed to ground
  input  wire logic [pllsy_pkg::REF_SEL_W-1:0] ref_divide_select_pulldown_in,
  input  wire logic [pllsy_pkg::NVAL_W-1:0]    feedback_divide_value_pulldown_in,
  input  wire logic                          tr_select_pulldown_in,
  // Analog-side clocks
  input  wire logic                          vco_feedback_in,
  input  wire logic                          ref_osc_input_in,
  output logic                               ref_osc_output_out,
  // Detector and lock outputs
  output logic                               single_ended_phase_error_out,
  output logic                               single_ended_phase_error_oe_out,
  output logic                               phase_ref_side_b_out,
  output logic                               phase_vco_side_b_out,
  output logic                               divided_vco_signal_out,
  output logic                               divided_reference_signal_out,
  output logic                               lock_indicator_out,
  // AHB-Lite slave
  input  wire logic                          hsel_in,
  input  wire logic [31:0]                   haddr_in,
  input  wire logic [1:0]                    htrans_in,
  input  wire logic                          hwrite_in,
  input  wire logic [2:0]                    hsize_in,
  input  wire logic [31:0]                   hwdata_in,
  input  wire logic                          hready_in,
  output logic [31:0]                        hrdata_out,
  output logic                               hreadyout_out,
  output logic                               hresp_out
);
  import pllsy_pkg::*;

  logic [PIN_W-1:0]     pin_level;
  logic                 vco_rise;
  logic                 ref_rise;
  logic                 ref_level;
  logic [REF_SEL_W-1:0] pin_ref_sel;
  logic [NVAL_W-1:0]    pin_nval;
  logic                 pin_tr;
  logic [REF_SEL_W-1:0] ref_sel;
  logic [NVAL_W-1:0]    n_val;
  logic                 tr_sel;
  logic [RCNT_W-1:0]    ref_ratio;
  logic [NCNT_W-1:0]    n_total;
  logic                 n_reload;
  logic                 r_reload;
  logic                 both;
  logic                 clr_both;
  logic                 nxt_up;
  logic                 nxt_dn;
  logic                 bus_take;
  logic [31:0]          rd_mux;
  logic [ADDR_W-1:0]    take_addr;

  logic [4:0]           cfg_ff;
  logic [NVAL_W-1:0]    nval_ff;
  logic [NCNT_W-1:0]    n_cnt_ff;
  logic [RCNT_W-1:0]    r_cnt_ff;
  logic                 dvco_ff;
  logic                 dref_ff;
  logic                 up_ff;
  logic                 dn_ff;
  logic [1:0]           both_cnt_ff;
  logic                 pd_out_ff;
  logic                 pd_oe_ff;
  logic                 phr_b_ff;
  logic                 phv_b_ff;
  logic                 lock_ff;
  logic                 wr_pend_ff;
  logic [ADDR_W-1:0]    wr_addr_ff;
  logic [31:0]          rdata_ff;

  // Static pins are slow switches, but still cross into this clock
  pllsy_pin_sync #(.WIDTH(PIN_W)) u_pin_sync (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .pin_in     ({ref_divide_select_pulldown_in, feedback_divide_value_pulldown_in,
                  tr_select_pulldown_in}),
    .level_out  (pin_level),
    .rise_out   ()
  );

  // VCO feedback edges; input rate must stay well under a quarter of the clock
  pllsy_pin_sync #(.WIDTH(1)) u_vco_sync (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .pin_in     (vco_feedback_in),
    .level_out  (),
    .rise_out   (vco_rise)
  );

  // Reference edges, crystal or external source on the same pin
  pllsy_pin_sync #(.WIDTH(1)) u_ref_sync (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .pin_in     (ref_osc_input_in),
    .level_out  (ref_level),
    .rise_out   (ref_rise)
  );

  // Oscillator inverter; left open when an external reference is used
  assign ref_osc_output_out = ~ref_level;

  // Pull-ups: an open pin shows zero pulldown, so the bit reads one
  assign pin_ref_sel = ~pin_level[PIN_W-1 -: REF_SEL_W];
  assign pin_nval    = ~pin_level[NVAL_W:1];
  assign pin_tr      = ~pin_level[0];

  // Software override takes the place of the pins when enabled
  assign ref_sel = cfg_ff[CFG_OVR_BIT] ? cfg_ff[CFG_SEL_LSB +: REF_SEL_W] : pin_ref_sel;
  assign n_val   = cfg_ff[CFG_OVR_BIT] ? nval_ff : pin_nval;
  assign tr_sel  = cfg_ff[CFG_OVR_BIT] ? cfg_ff[CFG_TR_BIT] : pin_tr;

  // Reference ratio lookup
  assign ref_ratio = (ref_sel == 3'h0) ? REF_DIV_0 :
                     (ref_sel == 3'h1) ? REF_DIV_1 :
                     (ref_sel == 3'h2) ? REF_DIV_2 :
                     (ref_sel == 3'h3) ? REF_DIV_3 :
                     (ref_sel == 3'h4) ? REF_DIV_4 :
                     (ref_sel == 3'h5) ? REF_DIV_5 :
                     (ref_sel == 3'h6) ? REF_DIV_6 : REF_DIV_7;

  // Offset adder; 15 bits so N plus offset never wraps
  assign n_total = {1'b0, n_val} + (tr_sel ? NCNT_RESET : TR_OFFSET);

  // Reload on the edge that would take the count to zero
  assign n_reload = vco_rise && (n_cnt_ff <= 15'h0001);
  assign r_reload = ref_rise && (r_cnt_ff <= 14'h0001);

  // Divide-by-N counter, advanced only by feedback edges
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      n_cnt_ff <= NCNT_RESET;
      dvco_ff  <= 1'b0;
    end else begin
      if (n_reload) begin
        n_cnt_ff <= n_total;
      end else if (vco_rise) begin
        n_cnt_ff <= n_cnt_ff - 15'h0001;
      end
      dvco_ff <= n_reload;
    end
  end

  // Reference divider
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r_cnt_ff <= RCNT_RESET;
      dref_ff  <= 1'b0;
    end else begin
      if (r_reload) begin
        r_cnt_ff <= ref_ratio;
      end else if (ref_rise) begin
        r_cnt_ff <= r_cnt_ff - 14'h0001;
      end
      dref_ff <= r_reload;
    end
  end

  assign divided_vco_signal_out       = dvco_ff;
  assign divided_reference_signal_out = dref_ff;

  // Phase detector state; a new edge wins over the clear of both flags
  assign both     = up_ff & dn_ff;
  assign clr_both = both && (both_cnt_ff == MIN_PULSE_LAST);
  assign nxt_up   = r_reload | (up_ff & ~clr_both);
  assign nxt_dn   = n_reload | (dn_ff & ~clr_both);

  // Detector flags and minimum-width counter
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      up_ff       <= 1'b0;
      dn_ff       <= 1'b0;
      both_cnt_ff <= 2'h0;
    end else begin
      up_ff       <= nxt_up;
      dn_ff       <= nxt_dn;
      both_cnt_ff <= (both && !clr_both) ? both_cnt_ff + 2'h1 : 2'h0;
    end
  end

  // Registered outputs; up means reference first, so VCO lags
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pd_out_ff <= 1'b0;
      pd_oe_ff  <= 1'b0;
      phr_b_ff  <= 1'b1;
      phv_b_ff  <= 1'b1;
      lock_ff   <= 1'b1;
    end else begin
      pd_out_ff <= up_ff & ~dn_ff;
      pd_oe_ff  <= up_ff ^ dn_ff;
      phr_b_ff  <= ~up_ff;
      phv_b_ff  <= ~dn_ff;
      lock_ff   <= ~(up_ff ^ dn_ff);
    end
  end

  assign single_ended_phase_error_out    = pd_out_ff;
  assign single_ended_phase_error_oe_out = pd_oe_ff;
  assign phase_ref_side_b_out            = phr_b_ff;
  assign phase_vco_side_b_out            = phv_b_ff;
  assign lock_indicator_out              = lock_ff;

  // AHB-Lite decode; zero wait states, whole words only
  assign bus_take  = hsel_in && hready_in && htrans_in[1];
  assign take_addr = haddr_in[ADDR_W-1:0];
  assign rd_mux    = (take_addr == OFS_CONFIG) ? {27'h000_0000, cfg_ff} :
                     (take_addr == OFS_NVALUE) ? {18'h0_0000, nval_ff} :
                     (take_addr == OFS_STATUS) ? {29'h0000_0000, dn_ff, up_ff, lock_ff} :
                     (take_addr == OFS_NCOUNT) ? {17'h0_0000, n_cnt_ff} : WORD_ZERO;
  assign hrdata_out    = rdata_ff;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  // Address phase capture and read data
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
      rdata_ff   <= WORD_ZERO;
    end else begin
      wr_pend_ff <= bus_take && hwrite_in;
      wr_addr_ff <= take_addr;
      if (bus_take && !hwrite_in) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // Data phase writes; unmapped writes are dropped
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_ff  <= CFG_RESET;
      nval_ff <= NVAL_RESET;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == OFS_CONFIG) begin
        cfg_ff <= hwdata_in[4:0];
      end
      if (wr_addr_ff == OFS_NVALUE) begin
        nval_ff <= hwdata_in[NVAL_W-1:0];
      end
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  // Starts on a fresh coincidence so a restart after a double reload is not mistaken
  sequence s_both_two;
    (both && both_cnt_ff == 2'h0) ##1 both;
  endsequence

  a_ref_ratio_code: assert property (ref_sel == 3'h6 |-> ref_ratio == 14'h096A)
    else $error("reference ratio wrong for code six");
  a_ref_reload_val: assert property (r_reload |=> r_cnt_ff == $past(ref_ratio))
    else $error("reference divider reloaded wrong value");
  a_n_reload_val: assert property (n_reload |=> n_cnt_ff == $past(n_total))
    else $error("N counter reloaded wrong value");
  a_n_count_step: assert property ((vco_rise && !n_reload) |=>
      n_cnt_ff == $past(n_cnt_ff) - 15'h0001)
    else $error("N counter did not step on feedback edge");
  a_n_count_hold: assert property (!vco_rise |=> $stable(n_cnt_ff))
    else $error("N counter moved without feedback edge");
  a_tr_offset_add: assert property (!tr_sel |-> n_total == {1'b0, n_val} + 15'h0358)
    else $error("offset not added with select low");
  a_pin_pullup: assert property (!cfg_ff[CFG_OVR_BIT] && pin_level == '0 |->
      (n_val == 14'h3FFF) && tr_sel && (ref_sel == 3'h7))
    else $error("open pins not read as ones");
  a_dvco_pin_copy: assert property (n_reload |=> divided_vco_signal_out ##1 !divided_vco_signal_out
      or n_reload)
    else $error("divided VCO pin not matching detector input");
  a_vco_lead_out: assert property ((dn_ff && !up_ff) |=>
      !phase_vco_side_b_out && phase_ref_side_b_out && single_ended_phase_error_oe_out
      && !single_ended_phase_error_out)
    else $error("VCO lead not reported");
  a_vco_lag_out: assert property ((up_ff && !dn_ff) |=>
      !phase_ref_side_b_out && phase_vco_side_b_out && single_ended_phase_error_out)
    else $error("VCO lag not reported");
  a_pd_float: assert property ((up_ff == dn_ff) |=> !single_ended_phase_error_oe_out)
    else $error("single-ended output driven in coincidence");
  a_both_short: assert property (s_both_two |=> !both || $past(r_reload || n_reload))
    else $error("coincident pulse exceeds minimum width");
  a_lock_flag: assert property ((up_ff ^ dn_ff) |=> !lock_indicator_out ##0
      $past(up_ff ^ dn_ff))
    else $error("lock flag high while out of lock");

endmodule : pllsy_core

// ### rtl/pllsy_pkg.sv
// Shared constants for the parallel-programmed synthesizer core
package pllsy_pkg;

  // Clock rate and timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MIN_PULSE_NS  = 40;
  localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  MIN_PULSE_LAST = 2'(MIN_PULSE_CYC - 1);

  // Field widths
  localparam int unsigned REF_SEL_W = 3;
  localparam int unsigned NVAL_W    = 14;
  localparam int unsigned NCNT_W    = 15;
  localparam int unsigned RCNT_W    = 14;
  localparam int unsigned PIN_W     = REF_SEL_W + NVAL_W + 1;

  // Reference divide ratios per select code
  localparam logic [RCNT_W-1:0] REF_DIV_0 = 14'h0008;
  localparam logic [RCNT_W-1:0] REF_DIV_1 = 14'h0080;
  localparam logic [RCNT_W-1:0] REF_DIV_2 = 14'h0100;
  localparam logic [RCNT_W-1:0] REF_DIV_3 = 14'h0200;
  localparam logic [RCNT_W-1:0] REF_DIV_4 = 14'h0400;
  localparam logic [RCNT_W-1:0] REF_DIV_5 = 14'h0800;
  localparam logic [RCNT_W-1:0] REF_DIV_6 = 14'h096A;
  localparam logic [RCNT_W-1:0] REF_DIV_7 = 14'h2000;

  // Transmit/receive offset
  localparam logic [NCNT_W-1:0] TR_OFFSET = 15'h0358;

  // Register map (byte addresses)
  localparam int unsigned       ADDR_W      = 12;
  localparam logic [ADDR_W-1:0] OFS_CONFIG  = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_NVALUE  = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_NCOUNT  = 12'h00C;

  // Config register fields
  localparam int unsigned CFG_OVR_BIT  = 0;
  localparam int unsigned CFG_SEL_LSB  = 1;
  localparam int unsigned CFG_TR_BIT   = 4;

  // Reset values
  localparam logic [4:0]        CFG_RESET  = 5'h1E;
  localparam logic [NVAL_W-1:0] NVAL_RESET = 14'h3FFF;
  localparam logic [NCNT_W-1:0] NCNT_RESET = 15'h0000;
  localparam logic [RCNT_W-1:0] RCNT_RESET = 14'h0000;
  localparam logic [31:0]       WORD_ZERO  = 32'h0000_0000;

endpackage : pllsy_pkg

// ### rtl/pllsy_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and rise strobe
`timescale 1ns/100ps
module pllsy_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out
);
  import pllsy_pkg::*;

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] agreed_ff;
  logic [WIDTH-1:0] rise_ff;
  logic [WIDTH-1:0] nxt_agreed;

  // New level only once stages two and three agree; stage one stays private
  assign nxt_agreed = (s2_ff & s3_ff) | (agreed_ff & (s2_ff | s3_ff));
  assign level_out  = agreed_ff;
  assign rise_out   = rise_ff;

  // Shift chain and filtered level
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_ff     <= '0;
      s2_ff     <= '0;
      s3_ff     <= '0;
      agreed_ff <= '0;
      rise_ff   <= '0;
    end else begin
      s1_ff     <= pin_in;
      s2_ff     <= s1_ff;
      s3_ff     <= s2_ff;
      agreed_ff <= nxt_agreed;
      rise_ff   <= nxt_agreed & ~agreed_ff;
    end
  end

endmodule : pllsy_pin_sync

// ### dv/pllsy_far_model.sv
// Far-side model: VCO, reference source and programming switches
`timescale 1ns/100ps
module pllsy_far_model (
  input  wire logic        ref_clk_in,
  input  wire logic        vco_en_in,
  input  wire logic        ref_en_in,
  input  wire logic [13:0] n_value_in,
  input  wire logic [2:0]  ref_code_in,
  input  wire logic        tr_high_in,
  output logic             vco_out,
  output logic             ref_osc_out,
  output logic [13:0]      n_pd_out,
  output logic [2:0]       rs_pd_out,
  output logic             tr_pd_out
);
  logic [1:0] vco_cnt_ff = 2'h0;
  logic [1:0] ref_cnt_ff = 2'h0;
  logic       vco_ff     = 1'b0;
  logic       osc_ff     = 1'b0;
  // One driver per output; the toggling lives in the flops
  assign vco_out     = vco_ff;
  assign ref_osc_out = osc_ff;
  // Closed switch grounds a bit; an open one reads one
  assign n_pd_out  = ~n_value_in;
  assign rs_pd_out = ~ref_code_in;
  assign tr_pd_out = ~tr_high_in;
  // Three clocks per phase, so the sampler never drops an edge
  always @(posedge ref_clk_in) begin
    if (!vco_en_in) begin
      vco_ff     <= 1'b0;
      vco_cnt_ff <= 2'h0;
    end else begin
      vco_cnt_ff <= (vco_cnt_ff == 2'h0) ? 2'h2 : vco_cnt_ff - 2'h1;
      if (vco_cnt_ff == 2'h0) vco_ff <= ~vco_ff;
    end
    if (!ref_en_in) begin
      osc_ff     <= 1'b0;
      ref_cnt_ff <= 2'h0;
    end else begin
      ref_cnt_ff <= (ref_cnt_ff == 2'h0) ? 2'h2 : ref_cnt_ff - 2'h1;
      if (ref_cnt_ff == 2'h0) osc_ff <= ~osc_ff;
    end
  end
endmodule : pllsy_far_model

// ### dv/parallel_pll_synth_core_tb_top.sv
// Self-checking bench for the synthesizer core
`timescale 1ns/100ps
module parallel_pll_synth_core_tb_top;
  import pllsy_pkg::*;
  localparam int          LIMIT   = 105000;
  localparam int          OSC_PER = 6;
  localparam logic [31:0] TR_ADD  = 32'h0000_0358;
  logic        ref_clk  = 1'b0;
  logic        rst_b    = 1'b0;
  logic        vco_en   = 1'b0;
  logic        ref_en   = 1'b0;
  logic [13:0] n_value  = 14'h3FFF;
  logic [2:0]  ref_code = 3'h7;
  logic        tr_high  = 1'b1;
  logic        hsel     = 1'b0;
  logic        hwrite   = 1'b0;
  logic [1:0]  htrans   = 2'h0;
  logic [31:0] haddr    = 32'h0000_0000;
  logic [31:0] hwdata   = 32'h0000_0000;
  logic [2:0]  hsize    = 3'h2;
  logic [31:0] hrdata;
  logic [13:0] n_pd;
  logic [2:0]  rs_pd;
  logic        vco, osc, tr_pd, osc_inv, pe, pe_oe, ref_b, vco_b, dvco, dref, lock, hready, hresp;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [15:0] ratio_tbl [8] = '{16'h0008, 16'h0080, 16'h0100, 16'h0200,
                                 16'h0400, 16'h0800, 16'h096A, 16'h2000};

  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

  pllsy_far_model u_far (.ref_clk_in(ref_clk), .vco_en_in(vco_en), .ref_en_in(ref_en),
    .n_value_in(n_value), .ref_code_in(ref_code), .tr_high_in(tr_high), .vco_out(vco),
    .ref_osc_out(osc), .n_pd_out(n_pd), .rs_pd_out(rs_pd), .tr_pd_out(tr_pd));

  pllsy_core u_dut (.ref_clk_in(ref_clk), .rst_b_in(rst_b),
    .ref_divide_select_pulldown_in(rs_pd), .feedback_divide_value_pulldown_in(n_pd),
    .tr_select_pulldown_in(tr_pd), .vco_feedback_in(vco), .ref_osc_input_in(osc),
    .ref_osc_output_out(osc_inv), .single_ended_phase_error_out(pe),
    .single_ended_phase_error_oe_out(pe_oe), .phase_ref_side_b_out(ref_b),
    .phase_vco_side_b_out(vco_b), .divided_vco_signal_out(dvco),
    .divided_reference_signal_out(dref), .lock_indicator_out(lock), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // Hang guard: a stuck wait ends here as a mismatch
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  // One single AHB-Lite transfer; holds each phase until hready
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask : xfer

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    xfer(1'b0, a, WORD_ZERO, d);
    chk($sformatf("reg %h", a), exp, d);
  endtask : rd_chk

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] d;
    xfer(1'b1, a, wd, d);
  endtask : wr

  task automatic do_reset(input logic [2:0] code, input logic [13:0] n, input logic tr);
    @(posedge ref_clk);
    rst_b    <= 1'b0;
    vco_en   <= 1'b0;
    ref_en   <= 1'b0;
    ref_code <= code;
    n_value  <= n;
    tr_high  <= tr;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask : do_reset

  // Cycles between two divider pulses, sampled mid-cycle
  task automatic gap(input logic use_vco, output int n);
    int t;
    t = 0;
    n = 1;
    while ((use_vco ? dvco : dref) !== 1'b1 && t < 60000) begin
      @(negedge ref_clk);
      t++;
    end
    @(negedge ref_clk);
    while ((use_vco ? dvco : dref) !== 1'b1 && n < 60000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : gap

  // One VCO period with the divider idle: the first edge loads it
  task automatic one_vco();
    vco_en <= 1'b1;
    repeat (5) @(posedge ref_clk);
    vco_en <= 1'b0;
    repeat (10) @(posedge ref_clk);
  endtask : one_vco

  task automatic reg_case();
    do_reset(3'h7, 14'h3FFF, 1'b1);
    chk("osc_inv", 32'h0000_0001, 32'(osc_inv));
    chk("hresp", 32'h0000_0000, 32'(hresp));
    chk("hready", 32'h0000_0001, 32'(hready));
    rd_chk(OFS_CONFIG, 32'h0000_001E);
    rd_chk(OFS_NVALUE, 32'h0000_3FFF);
    rd_chk(OFS_STATUS, 32'h0000_0001);
    rd_chk(OFS_NCOUNT, 32'h0000_0000);
    wr(12'h010, 32'hFFFF_FFFF);
    wr(OFS_STATUS, 32'h0000_0006);
    rd_chk(OFS_STATUS, 32'h0000_0001);
    rd_chk(12'h010, 32'h0000_0000);
    wr(OFS_CONFIG, 32'h0000_0011);
    wr(OFS_NVALUE, 32'h0000_0005);
    rd_chk(OFS_CONFIG, 32'h0000_0011);
    rd_chk(OFS_NVALUE, 32'h0000_0005);
    one_vco();
    rd_chk(OFS_NCOUNT, 32'h0000_0005);
    $display("register case done");
  endtask : reg_case

  task automatic ref_case(input logic [2:0] code);
    int g;
    do_reset(code, 14'h0003, 1'b1);
    ref_en <= 1'b1;
    gap(1'b0, g);
    chk("ref_ratio", 32'(ratio_tbl[code]) * OSC_PER, 32'(g));
    $display("ref case code %0d done", code);
  endtask : ref_case

  task automatic n_case(input logic [13:0] n, input logic tr, input logic meas);
    int          g;
    logic [31:0] total;
    total = 32'(n) + (tr ? WORD_ZERO : TR_ADD);
    do_reset(3'h7, n, tr);
    if (meas) begin
      vco_en <= 1'b1;
      gap(1'b1, g);
      chk("n_ratio", total * OSC_PER, 32'(g));
    end else begin
      one_vco();
      rd_chk(OFS_NCOUNT, total);
    end
    $display("n case %0d tr %0d done", n, tr);
  endtask : n_case

  // Counts detector states over a window; mode 0 lead, 1 lag, 2 lock
  task automatic phase_case(input logic [13:0] n, input logic [1:0] mode);
    int         vlo = 0;
    int         rlo = 0;
    int         blo = 0;
    int         llo = 0;
    int         neg = 0;
    int         pos = 0;
    int         olo = 0;
    logic [4:0] exp;
    do_reset(3'h0, n, 1'b1);
    vco_en <= 1'b1;
    ref_en <= 1'b1;
    repeat (600) begin
      @(negedge ref_clk);
      vlo += int'(vco_b === 1'b0 && ref_b === 1'b1);
      rlo += int'(ref_b === 1'b0 && vco_b === 1'b1);
      blo += int'(ref_b === 1'b0 && vco_b === 1'b0);
      llo += int'(lock === 1'b0);
      neg += int'(pe_oe === 1'b1 && pe === 1'b0);
      pos += int'(pe_oe === 1'b1 && pe === 1'b1);
      olo += int'(osc_inv === 1'b0);
    end
    exp = (mode == 2'd0) ? 5'b10101 : (mode == 2'd1) ? 5'b01011 : 5'b00000;
    chk("detector", 32'(exp), 32'({vlo > 0, rlo > 0, neg > 0, pos > 0, llo > 0}));
    if (mode == 2'd2) chk("both_low", 32'h0000_0001, 32'(blo > 0));
    chk("osc_inv_low", 32'h0000_0001, 32'(olo > 0));
    $display("phase case mode %0d done", mode);
  endtask : phase_case

  // Main sequence
  initial begin
    reg_case();
    for (int c = 0; c < 8; c++) ref_case(3'(c));
    n_case(14'h3FFF, 1'b1, 1'b0);
    n_case(14'h3FFF, 1'b0, 1'b0);
    n_case(14'h2000, 1'b1, 1'b0);
    n_case(14'h0003, 1'b1, 1'b1);
    n_case(14'h0005, 1'b0, 1'b1);
    phase_case(14'h0003, 2'd0);
    phase_case(14'h0010, 2'd1);
    phase_case(14'h0008, 2'd2);
    finish_test();
  end
endmodule : parallel_pll_synth_core_tb_top
